// ===== verilog/chan_mon_pkg.sv
// constants for the bus channel fault monitor
// assumes a 250 MHz reference clock and a byte-wide register port
`default_nettype none
package chan_mon_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [6:0] OFS_RX_STATUS = 7'h02;
   localparam logic [6:0] OFS_ENABLE = 7'h0d;
   localparam logic [6:0] OFS_SPREAD = 7'h20;
   localparam logic [6:0] OFS_PERIOD_LO = 7'h21;
   localparam logic [6:0] OFS_PERIOD_HI = 7'h22;
   localparam logic [6:0] OFS_GAP = 7'h23;
   localparam logic [6:0] OFS_CRC_LEN = 7'h24;
   localparam logic [6:0] OFS_CRC_POLY = 7'h25;
   localparam logic [6:0] OFS_CRC_SEED = 7'h26;
   // ****************************************
   // field positions
   // ****************************************
   localparam int B_ER = 7;
   localparam int B_TE = 6;
   localparam int B_SDS = 5;
   localparam int B_RNE = 4;
   localparam int B_ICL = 3;
   localparam int B_FIXA = 1;
   localparam int B_FIXB = 0;
   localparam int B_TS = 7;
   localparam int B_REPEATED_OVERCURRENT_DISABLE_FLAG = 6;
   localparam int B_SWH = 2;
   localparam int B_SWL = 1;
   localparam int B_EN = 0;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic FIXA_VAL = 1'b0;
   localparam logic FIXB_VAL = 1'b1;
   localparam logic [2:0] DEV_RST = 3'h0;
   localparam logic [15:0] PERIOD_RST = 16'h04e2;
   localparam logic [7:0] GAP_RST = 8'h04;
   localparam logic [7:0] GAP_MIN = 8'h01;
   localparam logic [3:0] CRC_LEN_RST = 4'h4;
   localparam logic [7:0] CRC_POLY_RST = 8'h11;
   localparam logic [7:0] CRC_SEED_RST = 8'h0a;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   // ****************************************
   // frame layout and timing
   // ****************************************
   localparam int ESW_DATA_BITS = 2;
   localparam int ESW_ADDR_BITS = 4;
   localparam int ESW_CMD_BITS = 4;
   localparam int ESW_CHECK_BITS = 4;
   localparam int ESW_BITS = ESW_DATA_BITS + ESW_ADDR_BITS
                             + ESW_CMD_BITS + ESW_CHECK_BITS;
   localparam int REF_PERIOD_PS = 4000;
   localparam int DEV_PERIOD_PS = 15625;
   localparam int MIN_RATE_BPS = 5000;
   localparam int MAX_BIT_CYCLES = 1000000000 / MIN_RATE_BPS
                                   / (REF_PERIOD_PS / 1000);
   localparam int ICL_DELAY_NS = 1000;
   localparam int ICL_CYCLES = (ICL_DELAY_NS * 1000 + REF_PERIOD_PS - 1)
                               / REF_PERIOD_PS;
   // deviation in 64 MHz periods, rounded down to reference cycles
   localparam int DEV_P1 = 16 * DEV_PERIOD_PS / REF_PERIOD_PS;
   localparam int DEV_P2 = 32 * DEV_PERIOD_PS / REF_PERIOD_PS;
   localparam int DEV_P3 = 64 * DEV_PERIOD_PS / REF_PERIOD_PS;
   localparam int DEV_P4 = 78 * DEV_PERIOD_PS / REF_PERIOD_PS;
endpackage
`default_nettype wire

// ===== verilog/bus_channel_fault_monitor.sv
// fault supervision, receive decision and spread bit clock, one channel
// assumes fault inputs and receive words are synchronous to ref_clk
//
// What this block does
// [RULE_01] idle over-current: drivers off after a short delay, set idle flag
// [RULE_02] signal-time over-current: drivers off until frame end, set flag
// [RULE_03] over-current two frames running: disable channel, open switches
// [RULE_04] channel thermal limit: disable drivers, set flag, open switches
// [RULE_05] pseudo bus thermal: only open switches and clear their bits
// [RULE_06] resistive short above threshold acts exactly like a hard short
// [RULE_07] high-line short: high and sum fail, low passes, fault-high case
// [RULE_08] high and low fail, sum passes: no error, deliver sum data
// [RULE_09] high-low short gives all ones on both paths, error set
// [RULE_10] all-ones word on high or low path sets the error flag
// [RULE_11] all three paths fail: error set, high path data reported
// [RULE_12] bit rate programmable, never slower than five kilobits
// [RULE_13] minimum gap of idle bits between successive frames
// [RULE_14] channel makes its own bit clock with random bit lengths
// [RULE_15] deviation code picks 0, 16, 32, 64 or 78 fast periods
// [RULE_16] no bit longer than base period plus selected deviation
// [RULE_17] short word frame is fourteen bits with four check bits
// [RULE_18] primary data from high or sum a, secondary from low or sum b
// [RULE_19] check code length, polynomial and seed programmable, 4/11/a
// [RULE_20] per-bit extension pseudo-random, from zero to deviation
// [RULE_21] flags stay until cleared, drivers off until enable rewritten
`timescale 1ns/10ps
`default_nettype none
module bus_channel_fault_monitor #(
   parameter int FRAME_W = chan_mon_pkg::ESW_BITS,
   parameter int MAX_BIT = chan_mon_pkg::MAX_BIT_CYCLES,
   parameter int ICL_DLY = chan_mon_pkg::ICL_CYCLES,
   parameter bit HAS_PSEUDO = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [6:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire logic overcurrent,
   input wire logic thermal_channel,
   input wire logic thermal_pseudo,
   input wire logic tx_start,
   input wire logic rx_done,
   input wire logic [FRAME_W-1:0] rx_high_word,
   input wire logic [FRAME_W-1:0] rx_low_word,
   input wire logic [FRAME_W-1:0] rx_sum_a_word,
   input wire logic [FRAME_W-1:0] rx_sum_b_word,
   output logic driver_enable,
   output logic pseudo_switch_high_ctl,
   output logic pseudo_switch_low_ctl,
   output logic bit_tick,
   output logic frame_active,
   output logic [FRAME_W-1:0] primary_data,
   output logic [FRAME_W-1:0] secondary_data,
   output logic rx_valid,
   output logic receive_error_flag
);
   // ****************************************
   // parameter checks
   // ****************************************
   if (FRAME_W < 8 || FRAME_W > 32)
      $error("frame width must lie in 8..32");
   if (MAX_BIT < 2 || MAX_BIT > 65535)
      $error("longest bit must fit the 16-bit period register");
   if (ICL_DLY < 1 || ICL_DLY > 511)
      $error("idle limit delay must fit nine bits");

   // a small period ceiling must not leave the reset period above it
   localparam logic [15:0] PER_RST =
      (MAX_BIT < int'(chan_mon_pkg::PERIOD_RST)) ? 16'(MAX_BIT)
                                                 : chan_mon_pkg::PERIOD_RST;

   typedef struct packed {
      logic er;
      logic te;
      logic signal_time_shutdown_flag;
      logic receive_not_empty_flag;
      logic idle_current_limit_flag;
      logic ts;
      logic repeated_overcurrent_disable_flag;
      logic sw_h;
      logic sw_l;
      logic en;
      logic [2:0] dev_sel;
      logic [15:0] period;
      logic [7:0] gap;
      logic [3:0] crc_len;
      logic [7:0] poly;
      logic [7:0] seed;
      logic [7:0] rd;
      logic [15:0] lfsr;
      logic [16:0] bit_cnt;
      logic [8:0] ext;
      logic tick;
      logic busy;
      logic sig;
      logic [7:0] bits_left;
      logic txn_off;
      logic oc_frame;
      logic oc_last;
      logic icl_pend;
      logic [8:0] icl_cnt;
      logic drv;
      logic [FRAME_W-1:0] prim;
      logic [FRAME_W-1:0] sec;
      logic valid;
   } state_t;

   state_t s;
   state_t next_s;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [8:0] dev_cycles(input logic [2:0] sel);
      case (sel) // [RULE_15]
         3'h0: dev_cycles = 9'h000;
         3'h1: dev_cycles = 9'(chan_mon_pkg::DEV_P1);
         3'h2: dev_cycles = 9'(chan_mon_pkg::DEV_P2);
         3'h3: dev_cycles = 9'(chan_mon_pkg::DEV_P3);
         3'h4: dev_cycles = 9'(chan_mon_pkg::DEV_P4);
         default: dev_cycles = 9'h000;
      endcase
   endfunction

   // serial check over the data bits, msb first
   function automatic logic crc_ok(input logic [FRAME_W-1:0] w,
                                   input logic [3:0] len,
                                   input logic [7:0] poly,
                                   input logic [7:0] seed);
      logic [7:0] c;
      logic [7:0] m;
      logic [7:0] top;
      logic fb;
      m = 8'(8'h01 << len) - 8'h01;
      top = m ^ (m >> 1);
      c = seed & m;
      for (int i = FRAME_W - 1; i >= 0; i--)
      begin
         if (i >= int'(len))
         begin
            fb = (|(c & top)) ^ w[i];
            c = ((c << 1) & m) ^ (fb ? (poly & m) : 8'h00);
         end
      end
      crc_ok = (((c ^ w[7:0]) & m) == 8'h00); // [RULE_19]
   endfunction

   // ****************************************
   // receive decision
   // ****************************************
   logic ok_h;
   logic ok_l;
   logic ok_s;
   logic ones;
   logic dec_err;
   logic [FRAME_W-1:0] dec_p;
   logic [FRAME_W-1:0] dec_s;

   always_comb
   begin
      ok_h = crc_ok(rx_high_word, s.crc_len, s.poly, s.seed);
      ok_l = crc_ok(rx_low_word, s.crc_len, s.poly, s.seed);
      ok_s = crc_ok(rx_sum_a_word, s.crc_len, s.poly, s.seed);
      ones = (&rx_high_word) || (&rx_low_word); // [RULE_09] [RULE_10]
      dec_p = rx_high_word;
      dec_s = rx_low_word;
      dec_err = 1'b1;
      if (ok_h && ok_l)
         dec_err = (rx_high_word != rx_low_word);
      else if (ok_h && ok_s)
      begin
         dec_err = (rx_high_word != rx_sum_a_word);
         if (!dec_err)
            dec_s = rx_sum_b_word; // [RULE_18]
      end
      else if (ok_l && ok_s)
      begin
         dec_err = (rx_low_word != rx_sum_a_word);
         if (!dec_err)
            dec_p = rx_sum_a_word; // [RULE_18]
      end
      else if (ok_s)
      begin
         // common-mode noise swamps both halves but not the sum
         dec_err = 1'b0; // [RULE_08]
         dec_p = rx_sum_a_word;
         dec_s = rx_sum_b_word;
      end
      // fault-high, fault-low and open line keep high/low data
      dec_err = dec_err | ones; // [RULE_07] [RULE_11]
   end

   // ****************************************
   // next state
   // ****************************************
   logic wr_st;
   logic wr_en_reg;
   logic frame_end;
   logic [8:0] dev_now;
   logic [16:0] limit;
   logic [18:0] scaled;
   logic [15:0] per_w;
   logic start_ok;

   always_comb
   begin
      next_s = s;
      wr_st = wr_en && (addr == chan_mon_pkg::OFS_RX_STATUS);
      wr_en_reg = wr_en && (addr == chan_mon_pkg::OFS_ENABLE);
      dev_now = dev_cycles(s.dev_sel);
      limit = {1'b0, s.period} + {8'h00, s.ext}; // [RULE_16]
      scaled = 19'(s.lfsr[8:0] * (dev_now + 9'h001));
      per_w = s.period;
      start_ok = tx_start && !s.busy && s.drv;
      frame_end = s.tick && s.sig && (s.bits_left == 8'h01);

      // software clears first; hardware sets below win
      if (wr_st)
      begin
         next_s.er = s.er & ~wr_data[chan_mon_pkg::B_ER];
         next_s.te = s.te & ~wr_data[chan_mon_pkg::B_TE];
         next_s.signal_time_shutdown_flag = s.signal_time_shutdown_flag & ~wr_data[chan_mon_pkg::B_SDS];
         next_s.idle_current_limit_flag = s.idle_current_limit_flag & ~wr_data[chan_mon_pkg::B_ICL];
      end
      if (rd_en && addr == chan_mon_pkg::OFS_RX_STATUS)
         next_s.receive_not_empty_flag = 1'b0;
      if (wr_en_reg)
      begin
         next_s.ts = s.ts & ~wr_data[chan_mon_pkg::B_TS];
         next_s.repeated_overcurrent_disable_flag = s.repeated_overcurrent_disable_flag & ~wr_data[chan_mon_pkg::B_REPEATED_OVERCURRENT_DISABLE_FLAG];
         next_s.en = wr_data[chan_mon_pkg::B_EN]; // [RULE_21]
         next_s.sw_h = wr_data[chan_mon_pkg::B_SWH] && HAS_PSEUDO;
         next_s.sw_l = wr_data[chan_mon_pkg::B_SWL] && HAS_PSEUDO;
      end
      if (wr_en)
      begin
         case (addr)
            chan_mon_pkg::OFS_SPREAD: next_s.dev_sel = wr_data[2:0];
            chan_mon_pkg::OFS_PERIOD_LO: per_w[7:0] = wr_data;
            chan_mon_pkg::OFS_PERIOD_HI: per_w[15:8] = wr_data;
            chan_mon_pkg::OFS_GAP: // [RULE_13]
               next_s.gap = (wr_data < chan_mon_pkg::GAP_MIN) ?
                            chan_mon_pkg::GAP_MIN : wr_data;
            chan_mon_pkg::OFS_CRC_LEN:
               next_s.crc_len = (wr_data[3:0] > 4'h8) ? 4'h8 : wr_data[3:0];
            chan_mon_pkg::OFS_CRC_POLY: next_s.poly = wr_data;
            chan_mon_pkg::OFS_CRC_SEED: next_s.seed = wr_data;
            default: next_s.rd = next_s.rd;
         endcase
         // slower than the floor rate is clamped, not stored
         if (per_w > 16'(MAX_BIT)) // [RULE_12]
            per_w = 16'(MAX_BIT);
         if (per_w < 16'h0002)
            per_w = 16'h0002;
         next_s.period = per_w;
      end

      // register read, data valid in the following cycle only
      next_s.rd = 8'h00;
      if (rd_en)
      begin
         case (addr)
            chan_mon_pkg::OFS_RX_STATUS:
               next_s.rd = {s.er, s.te, s.signal_time_shutdown_flag, s.receive_not_empty_flag, s.idle_current_limit_flag, 1'b0,
                            chan_mon_pkg::FIXA_VAL, chan_mon_pkg::FIXB_VAL};
            chan_mon_pkg::OFS_ENABLE:
               next_s.rd = {s.ts, s.repeated_overcurrent_disable_flag, 3'h0, s.sw_h, s.sw_l, s.en};
            chan_mon_pkg::OFS_SPREAD: next_s.rd = {5'h00, s.dev_sel};
            chan_mon_pkg::OFS_PERIOD_LO: next_s.rd = s.period[7:0];
            chan_mon_pkg::OFS_PERIOD_HI: next_s.rd = s.period[15:8];
            chan_mon_pkg::OFS_GAP: next_s.rd = s.gap;
            chan_mon_pkg::OFS_CRC_LEN: next_s.rd = {4'h0, s.crc_len};
            chan_mon_pkg::OFS_CRC_POLY: next_s.rd = s.poly;
            chan_mon_pkg::OFS_CRC_SEED: next_s.rd = s.seed;
            default: next_s.rd = 8'h00;
         endcase
      end

      // spread bit clock, free running
      next_s.lfsr = {s.lfsr[14:0],
                     s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
      next_s.tick = 1'b0;
      if (start_ok)
         next_s.bit_cnt = 17'h00000; // align the first bit to the start
      else if (s.bit_cnt >= limit - 17'h00001)
      begin
         next_s.bit_cnt = 17'h00000;
         next_s.tick = 1'b1; // [RULE_14]
         next_s.ext = scaled[17:9]; // [RULE_20]
      end
      else
         next_s.bit_cnt = s.bit_cnt + 17'h00001;

      // frame then idle gap
      if (tx_start && !s.drv)
         next_s.te = 1'b1;
      if (start_ok)
      begin
         next_s.busy = 1'b1;
         next_s.sig = 1'b1;
         next_s.bits_left = 8'(FRAME_W); // [RULE_17]
      end
      else if (s.busy && s.tick)
      begin
         if (s.bits_left != 8'h01)
            next_s.bits_left = s.bits_left - 8'h01;
         else if (s.sig)
         begin
            next_s.sig = 1'b0;
            next_s.bits_left = s.gap; // [RULE_13]
         end
         else
            next_s.busy = 1'b0;
      end

      // over-current, also a resistive short past the threshold
      if (overcurrent && s.sig) // [RULE_06]
      begin
         next_s.txn_off = 1'b1; // [RULE_02]
         next_s.signal_time_shutdown_flag = 1'b1;
         next_s.oc_frame = 1'b1;
      end
      if (frame_end)
      begin
         next_s.txn_off = 1'b0;
         next_s.oc_last = s.oc_frame || overcurrent;
         next_s.oc_frame = 1'b0;
         if (s.oc_last && (s.oc_frame || overcurrent)) // [RULE_03]
         begin
            next_s.repeated_overcurrent_disable_flag = 1'b1;
            next_s.en = 1'b0;
            next_s.sw_h = 1'b0;
            next_s.sw_l = 1'b0;
         end
      end
      if (overcurrent && !s.busy && s.en && !s.icl_pend) // [RULE_01]
      begin
         next_s.icl_pend = 1'b1;
         next_s.icl_cnt = 9'(ICL_DLY);
      end
      else if (s.icl_pend)
      begin
         next_s.icl_cnt = s.icl_cnt - 9'h001;
         if (s.icl_cnt == 9'h001)
         begin
            next_s.icl_pend = 1'b0;
            next_s.idle_current_limit_flag = 1'b1;
            next_s.en = 1'b0;
         end
      end
      if (thermal_channel) // [RULE_04]
      begin
         next_s.ts = 1'b1;
         next_s.en = 1'b0;
         next_s.sw_h = 1'b0;
         next_s.sw_l = 1'b0;
      end
      if (thermal_pseudo) // [RULE_05]
      begin
         next_s.sw_h = 1'b0;
         next_s.sw_l = 1'b0;
      end
      next_s.drv = next_s.en && !next_s.txn_off && !thermal_channel;

      // receive capture
      next_s.valid = rx_done;
      if (rx_done)
      begin
         next_s.prim = dec_p;
         next_s.sec = dec_s;
         next_s.receive_not_empty_flag = 1'b1;
         if (dec_err)
            next_s.er = 1'b1; // [RULE_21]
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.dev_sel <= chan_mon_pkg::DEV_RST;
         s.period <= PER_RST;
         s.gap <= chan_mon_pkg::GAP_RST;
         s.crc_len <= chan_mon_pkg::CRC_LEN_RST;
         s.poly <= chan_mon_pkg::CRC_POLY_RST;
         s.seed <= chan_mon_pkg::CRC_SEED_RST;
         s.lfsr <= chan_mon_pkg::LFSR_SEED;
      end
      else
         s <= next_s;
   end

   assign rd_data = s.rd;
   assign driver_enable = s.drv;
   assign pseudo_switch_high_ctl = s.sw_h;
   assign pseudo_switch_low_ctl = s.sw_l;
   assign bit_tick = s.tick;
   assign frame_active = s.sig;
   assign primary_data = s.prim;
   assign secondary_data = s.sec;
   assign rx_valid = s.valid;
   assign receive_error_flag = s.er;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence two_bad_frames;
      frame_end && s.oc_last && (s.oc_frame || overcurrent);
   endsequence

   a_idle_limit: assert property ( // [RULE_01]
      s.icl_pend && s.icl_cnt == 9'h001 && !wr_en
      |=> s.idle_current_limit_flag && !s.en ##1 !driver_enable)
      else $error("idle limit did not disable the channel");
   a_signal_off: assert property ( // [RULE_02]
      overcurrent && s.sig |=> s.signal_time_shutdown_flag && !driver_enable)
      else $error("signal-time over-current left drivers on");
   a_repeat_off: assert property ( // [RULE_03]
      two_bad_frames |=> s.repeated_overcurrent_disable_flag && !s.en && !pseudo_switch_high_ctl
      && !pseudo_switch_low_ctl)
      else $error("repeated over-current not latched");
   a_thermal_off: assert property ( // [RULE_04]
      thermal_channel |=> s.ts && !driver_enable && !pseudo_switch_low_ctl)
      else $error("thermal limit left channel running");
   a_pseudo_only: assert property ( // [RULE_05]
      thermal_pseudo && !thermal_channel && !overcurrent && !wr_en
      && !s.icl_pend && !frame_end
      |=> !pseudo_switch_high_ctl && $stable(s.ts) && $stable(s.en))
      else $error("pseudo thermal touched channel state");
   a_common_mode: assert property ( // [RULE_08]
      rx_done && !ok_h && !ok_l && ok_s && !ones
      |=> primary_data == $past(rx_sum_a_word)
      && secondary_data == $past(rx_sum_b_word))
      else $error("sum data not delivered under noise");
   a_all_bad: assert property ( // [RULE_11]
      rx_done && !ok_h && !ok_l && !ok_s
      |=> receive_error_flag && primary_data == $past(rx_high_word))
      else $error("open line not flagged");
   a_all_ones: assert property ( // [RULE_10]
      rx_done && (&rx_low_word) |=> receive_error_flag [*2])
      else $error("all-ones word not flagged");
   a_bit_bound: assert property ( // [RULE_16]
      $stable(s.dev_sel) && s.tick |-> s.ext <= dev_now)
      else $error("bit extension beyond deviation");
   a_rate_floor: assert property ( // [RULE_12]
      s.period <= 16'(MAX_BIT) && s.period >= 16'h0002)
      else $error("bit period outside its range");
   a_gap_kept: assert property ( // [RULE_13]
      frame_end |=> !frame_active [*2])
      else $error("frame restarted without a gap");
endmodule
`default_nettype wire

// ===== dv/sensor_slave_model.sv
// remote sensor model: answers every frame with three receive words
// assumes frame_active marks the frame and mode picks the bus fault
`timescale 1ns/10ps
`default_nettype none
module sensor_slave_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic frame_active,
   input wire logic [2:0] mode,
   input wire logic [9:0] payload,
   output logic rx_done,
   output logic [13:0] clean_word,
   output logic [13:0] hi_w,
   output logic [13:0] lo_w,
   output logic [13:0] sum_w
);
   logic fa_d;
   logic [3:0] c;
   // ********
   // answer words
   // ********
   always_comb
   begin
      c = 4'ha;
      for (int i = 9; i >= 0; i--)
         c = {c[2:0], 1'b0} ^ {3'h0, c[3] ^ payload[i]};
      clean_word = {payload, c};
      hi_w = clean_word;
      lo_w = clean_word;
      sum_w = clean_word;
      if (mode inside {3'h1, 3'h2, 3'h3})
         hi_w = clean_word ^ 14'h0001;
      if (mode inside {3'h2, 3'h3, 3'h6})
         lo_w = clean_word ^ 14'h0001;
      if (mode inside {3'h1, 3'h3, 3'h4})
         sum_w = clean_word ^ 14'h0001;
      if (mode inside {3'h4, 3'h5})
         hi_w = 14'h3fff;
      if (mode == 3'h4)
         lo_w = 14'h3fff;
      // stale words inverted so they never pass for fresh ones
      if (!rx_done)
      begin
         hi_w = ~hi_w;
         lo_w = ~lo_w;
         sum_w = ~sum_w;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fa_d <= 1'b0;
         rx_done <= 1'b0;
      end
      else
      begin
         fa_d <= frame_active;
         rx_done <= fa_d & ~frame_active;
      end
   end
endmodule
`default_nettype wire

// ===== dv/bus_channel_fault_monitor_tb_top.sv
// bench: registers, spread bit clock, receive decisions, fault shutdowns
// assumes the sensor model answers each frame on the receive words
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module bus_channel_fault_monitor_tb_top;
   localparam int PER = 8;
   localparam int IDLE_CURRENT_LIMIT_FLAG = 3;
   logic ref_clk, rst_n, wr_en, rd_en, overcurrent, thermal_channel;
   logic thermal_pseudo, tx_start, rx_done, drv, sw_h, sw_l, bit_tick;
   logic frame_active, rx_valid, err;
   logic [6:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [13:0] hw, lw, sw, g, prim, sec;
   logic [2:0] mode;
   int n_errors = 0, checks = 0, cyc = 0, nt, mn, mx;
   bus_channel_fault_monitor #(.MAX_BIT(100), .ICL_DLY(IDLE_CURRENT_LIMIT_FLAG))
      u_bus_channel_fault_monitor (.ref_clk, .rst_n, .addr, .wr_data,
      .wr_en, .rd_en, .rd_data, .overcurrent, .thermal_channel,
      .thermal_pseudo, .tx_start, .rx_done, .rx_high_word(hw),
      .rx_low_word(lw), .rx_sum_a_word(sw), .rx_sum_b_word(sw),
      .driver_enable(drv), .pseudo_switch_high_ctl(sw_h),
      .pseudo_switch_low_ctl(sw_l), .bit_tick, .frame_active,
      .primary_data(prim), .secondary_data(sec), .rx_valid,
      .receive_error_flag(err));
   sensor_slave_model u_sensor_slave_model (.ref_clk, .rst_n,
      .frame_active, .mode, .payload(10'h2a5), .rx_done,
      .clean_word(g), .hi_w(hw), .lo_w(lw), .sum_w(sw));
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   // ********
   // bus and frame helpers
   // ********
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e,
                     input logic [7:0] m, input string nm);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 `CHK(nm, e, rd_data & m)
      @(posedge ref_clk);
   endtask
   task automatic frame(input logic oc);
      int last;
      nt = 0;
      mn = 99999;
      mx = 0;
      last = 0;
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      #1;
      for (int i = 0; i < 20000 && frame_active !== 1'b0; i++)
      begin
         @(posedge ref_clk);
         #1;
         overcurrent <= oc && nt inside {[3:4]};
         if (oc && nt == 7 && bit_tick)
            `CHK("drivers cut", 1'b0, drv)
         if (bit_tick === 1'b1)
         begin
            if (nt > 0 && i - last < mn)
               mn = i - last;
            if (nt > 0 && i - last > mx)
               mx = i - last;
            nt++;
            last = i;
         end
      end
      `CHK("frame bits", 14, nt)
   endtask
   task automatic gap_wait(input int dc);
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 `CHK("gap refuse", 1'b0, frame_active)
      repeat (4 * (PER + dc) + 20) @(posedge ref_clk);
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_regs();
      logic [6:0] a[10] = '{7'h02, 7'h0d, 7'h20, 7'h21, 7'h22, 7'h23,
                            7'h24, 7'h25, 7'h26, 7'h7f};
      logic [7:0] e[10] = '{8'h01, 8'h00, 8'h00, 8'h64, 8'h00, 8'h04,
                            8'h04, 8'h11, 8'h0a, 8'h00};
      for (int k = 0; k < 10; k++)
         rd(a[k], e[k], 8'hff, "reset value");
      wr(7'h22, 8'h01);
      rd(7'h22, 8'h00, 8'hff, "slowest rate");
      wr(7'h21, 8'h00);
      rd(7'h21, 8'h02, 8'hff, "shortest bit");
      wr(7'h21, 8'(PER));
      wr(7'h0d, 8'h07);
      $display("test regs done");
   endtask
   task automatic t_dev();
      int n[5] = '{0, 16, 32, 64, 78};
      int dc;
      for (int k = 0; k < 5; k++)
      begin
         dc = n[k] * 15625 / 4000;
         wr(7'h20, 8'(k));
         rd(7'h20, 8'(k), 8'hff, "deviation code");
         frame(1'b0);
         `CHK("bit max", 1'b1, mx <= PER + dc)
         `CHK("bit min", 1'b1, mn >= PER)
         `CHK("spread", k > 0, mx > mn)
         gap_wait(dc);
      end
      wr(7'h20, 8'h00);
      $display("test deviation done");
   endtask
   task automatic t_rx(input logic [2:0] m, input logic e,
                       input logic [13:0] p, input logic [13:0] s,
                       input logic cd);
      mode <= m;
      wr(7'h02, 8'hf8);
      frame(1'b0);
      for (int i = 0; i < 10 && rx_valid !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      `CHK("rx_valid", 1'b1, rx_valid)
      if (cd)
         `CHK("primary", p, prim)
      if (cd)
         `CHK("secondary", s, sec)
      @(posedge ref_clk);
      #1 `CHK("error flag", e, err)
      gap_wait(0);
      $display("test rx mode %0d done", m);
   endtask
   task automatic t_fault();
      wr(7'h02, 8'hf8);
      frame(1'b1);
      rd(7'h02, 8'h20, 8'h28, "signal shutdown");
      gap_wait(0);
      wr(7'h0d, 8'h07);
      frame(1'b1);
      rd(7'h0d, 8'h40, 8'hc7, "repeat shutdown");
      `CHK("switches open", 3'b000, {drv, sw_h, sw_l})
      gap_wait(0);
      `CHK("stays off", 1'b0, drv)
      wr(7'h0d, 8'h47);
      `CHK("re-enable", 3'b111, {drv, sw_h, sw_l})
      thermal_channel <= 1'b1;
      repeat (3) @(posedge ref_clk);
      thermal_channel <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 `CHK("thermal", 3'b000, {drv, sw_h, sw_l})
      rd(7'h0d, 8'h80, 8'hc7, "thermal flag");
      wr(7'h0d, 8'h87);
      thermal_pseudo <= 1'b1;
      repeat (3) @(posedge ref_clk);
      thermal_pseudo <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 `CHK("pseudo thermal", 3'b100, {drv, sw_h, sw_l})
      rd(7'h0d, 8'h01, 8'hc7, "pseudo only");
      wr(7'h02, 8'hf8);
      overcurrent <= 1'b1;
      @(posedge ref_clk);
      #1 `CHK("idle delay", 1'b1, drv)
      repeat (IDLE_CURRENT_LIMIT_FLAG + 4) @(posedge ref_clk);
      overcurrent <= 1'b0;
      rd(7'h02, 8'h08, 8'h08, "idle limit");
      `CHK("idle off", 1'b0, drv)
      $display("test faults done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      {rst_n, wr_en, rd_en, overcurrent, thermal_channel} = 5'h00;
      {thermal_pseudo, tx_start, addr, wr_data, mode} = 20'h00000;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_dev();
      t_rx(3'h0, 1'b0, g, g, 1'b1);
      t_rx(3'h1, 1'b1, g ^ 14'h0001, g, 1'b1);
      t_rx(3'h2, 1'b0, g, g, 1'b1);
      t_rx(3'h3, 1'b1, g ^ 14'h0001, g ^ 14'h0001, 1'b1);
      t_rx(3'h4, 1'b1, 14'h3fff, 14'h3fff, 1'b1);
      t_rx(3'h5, 1'b1, g, g, 1'b0);
      t_rx(3'h6, 1'b0, g, g, 1'b1);
      t_fault();
      report_and_stop();
   end
endmodule
`default_nettype wire
